//--- design/job_fifo.sv
// Parameterised first-in first-out buffer with valid and ready on both sides.
module job_fifo import lcd_ctl_pkg::*; #(
   parameter int WIDTH = JOB_W,
   parameter int DEPTH = FIFO_DEPTH_DEF
) (
   // Clock, reset and clock enable.
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic clk_en,
   // Fill side.
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // Drain side.
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);

   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0] wr;
      logic [AW-1:0] rd;
      logic [AW:0] count;
   } fifo_state_s;

   fifo_state_s s_q;
   fifo_state_s s_d;
   logic push;
   logic pop;

   assign in_ready = (s_q.count != (AW+1)'(DEPTH));
   assign out_valid = (s_q.count != '0);
   assign out_data = s_q.mem[s_q.rd];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_comb begin
      s_d = s_q;
      if (push) begin
         s_d.mem[s_q.wr] = in_data;
         s_d.wr = (s_q.wr == AW'(DEPTH - 1)) ? '0 : s_q.wr + 1'b1;
      end
      if (pop) begin
         s_d.rd = (s_q.rd == AW'(DEPTH - 1)) ? '0 : s_q.rd + 1'b1;
      end
      if (push && !pop) begin
         s_d.count = s_q.count + 1'b1;
      end else if (pop && !push) begin
         s_d.count = s_q.count - 1'b1;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         s_q <= '0;
      end else if (clk_en) begin
         s_q <= s_d;
      end
   end

endmodule : job_fifo

//--- design/lcd_ram_bank_blink_control.sv
// Receiver, RAM store, bank selection and blinker of a segment display driver.
// What this block does
// R1: Store only when subaddress counter equals strap.
// R2: On mismatch skip store, still advance pointer.
// R3: Pointer overflow increments the subaddress counter.
// R4: Hand-over works inside a multi-address byte.
// R5: Device select loads the subaddress counter.
// R6: Four-plane mode shows bits 0,1,2,3 in turn.
// R7: Three-plane mode shows bits 0,1,2 in turn.
// R8: Two-plane default bank shows bits 0 and 1.
// R9: Static default bank shows bit 0.
// R10: Alternate output bank shows bit 2 (static) or bits 2 and 3.
// R11: Alternate input bank stores into bit 2 (static) or bits 2,3.
// R12: Input and output banks are held independently.
// R13: Normal blink divides by 92160, 184320, 368640.
// R14: Power-saving blink divides by 15360, 30720, 61440.
// R15: Alternate-bank blink swaps banks at blink rate.
// R16: Display blanks while enable bit is clear.
// R17: Slave receiver only; SDA driven for acknowledge.
// R18: Acknowledge holds SDA low through ninth pulse.
// R19: Detect start, stop and idle bus.
// R20: Master keeps SDA stable while SCL high.
// R21: Power-saving overload stretches SCL low until done.
// R22: Selection uses slave address, select value, strap.
// R23: Pointer steps by eight, four, three, two.
// R24: Bank bits ignored in three and four-plane modes.
// R25: Blink command carries rate and mode bit.
// R26: Device select carries a three-bit subaddress.
module lcd_ram_bank_blink_control import lcd_ctl_pkg::*; #(
   parameter int BLINK_DIV_N1 = 92160,
   parameter int BLINK_DIV_N2 = 184320,
   parameter int BLINK_DIV_N3 = 368640,
   parameter int BLINK_DIV_P1 = 15360,
   parameter int BLINK_DIV_P2 = 30720,
   parameter int BLINK_DIV_P3 = 61440,
   parameter int FIFO_DEPTH = FIFO_DEPTH_DEF
) (
   // Clock, reset and clock enable.
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic clk_en,
   // Serial bus pins.
   input wire logic scl_in,
   output logic scl_out,
   output logic scl_oe,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   // Straps.
   input wire logic hw_subaddr_bit0,
   input wire logic hw_subaddr_bit1,
   input wire logic hw_subaddr_bit2,
   input wire logic slave_addr_sel,
   // Display side.
   input wire logic mux_step,
   output logic [1:0] bp_phase,
   output logic [RAM_WORDS-1:0] seg_data,
   output logic drive_mode_hi,
   output logic drive_mode_lo,
   output logic bias_half,
   output logic low_power_select,
   output logic display_enable
);

   typedef struct packed {
      logic [PIN_COUNT-1:0] sync1;
      logic [PIN_COUNT-1:0] sync2;
      logic [PIN_COUNT-1:0] sync3;
      logic [PIN_COUNT-1:0] lvl;
      logic [1:0] prev;
      rx_state_e rx;
      logic [3:0] bitcnt;
      logic [7:0] shift;
      logic pending;
      logic ack;
      cfg_s cfg;
      logic [4:0] ptr;
      logic [2:0] subaddr;
      logic [18:0] blink_cnt;
      logic blink_on;
      logic busy;
      write_job_s job;
      logic [2:0] k;
      logic [7:0] wait_cnt;
      logic [1:0] phase;
      logic [RAM_WORDS-1:0] seg;
      logic [RAM_WORDS-1:0][RAM_BITS-1:0] ram;
   } state_s;

   state_s s_q;
   state_s s_d;

   logic scl_f;
   logic sda_f;
   logic [2:0] hw_sub;
   logic start_c;
   logic stop_c;
   logic scl_rise;
   logic scl_fall;
   logic [5:0] sum_c;
   logic ovf_c;
   logic [4:0] next_ptr_c;
   logic match_cur;
   logic match_next;
   logic addr_ok;
   logic need_push;
   logic take_c;
   logic we_c;
   logic bankable;
   logic out_sel;
   logic blank_c;
   logic [1:0] row_c;
   logic [18:0] half_c;
   write_job_s job_c;
   logic fifo_in_ready;
   logic fifo_out_valid;
   write_job_s fifo_out_data;

   assign scl_f = s_q.lvl[PIN_SCL];
   assign sda_f = s_q.lvl[PIN_SDA];
   assign hw_sub = s_q.lvl[PIN_SUB0+2:PIN_SUB0];
   assign start_c = scl_f && s_q.prev[PIN_SCL] && s_q.prev[PIN_SDA] && !sda_f; // R19
   assign stop_c = scl_f && s_q.prev[PIN_SCL] && !s_q.prev[PIN_SDA] && sda_f; // R19
   assign scl_rise = scl_f && !s_q.prev[PIN_SCL];
   assign scl_fall = !scl_f && s_q.prev[PIN_SCL];

   // Pointer bookkeeping happens at byte time, so the job already knows which of its addresses fall past the end.
   assign sum_c = {1'b0, s_q.ptr} + {2'b00, step_of(s_q.cfg.mode)}; // R23
   assign ovf_c = (sum_c >= 6'd24);
   assign next_ptr_c = ovf_c ? 5'(sum_c - 6'd24) : sum_c[4:0];
   assign match_cur = (s_q.subaddr == hw_sub); // R1
   assign match_next = (3'(s_q.subaddr + 3'h1) == hw_sub); // R4
   assign addr_ok = (s_q.shift[7:2] == SLAVE_ADDR_HI) && (s_q.shift[1] == s_q.lvl[PIN_SA]) && !s_q.shift[0]; // R22
   assign need_push = s_q.pending && (s_q.rx == RX_DATA) && (match_cur || (match_next && ovf_c));
   assign take_c = s_q.pending && (!need_push || fifo_in_ready);
   assign job_c = '{ptr: s_q.ptr, match_cur: match_cur, match_next: match_next, mode: s_q.cfg.mode,
                    bank: s_q.cfg.in_bank, data: s_q.shift};

   // Only static and two-plane modes have an alternate bank.
   assign bankable = (s_q.cfg.mode == MODE_STATIC) || (s_q.cfg.mode == MODE_1_2); // R24
   assign out_sel = bankable && (s_q.cfg.out_bank ^ (s_q.cfg.blink_alt && (s_q.cfg.blink_rate != 2'h0) && !s_q.blink_on)); // R15
   assign row_c = {out_sel, 1'b0} + s_q.phase; // R6 R7 R8 R9 R10
   assign blank_c = !s_q.cfg.enable || ((s_q.cfg.blink_rate != 2'h0) && !s_q.cfg.blink_alt && !s_q.blink_on); // R16

   always_comb begin
      int div_c;
      div_c = BLINK_DIV_N1;
      unique case ({s_q.cfg.low_power, s_q.cfg.blink_rate})
         3'b001: div_c = BLINK_DIV_N1; // R13
         3'b010: div_c = BLINK_DIV_N2; // R13
         3'b011: div_c = BLINK_DIV_N3; // R13
         3'b101: div_c = BLINK_DIV_P1; // R14
         3'b110: div_c = BLINK_DIV_P2; // R14
         3'b111: div_c = BLINK_DIV_P3; // R14
         3'b000, 3'b100: div_c = 2;
      endcase
      half_c = 19'(div_c / 2);
   end

   always_comb begin
      logic [5:0] a6;
      logic [4:0] a;
      logic en;
      logic [1:0] base;
      int b;
      int idx;
      a6 = '0;
      a = '0;
      en = 1'b0;
      base = 2'h0;
      b = 0;
      idx = 0;
      we_c = 1'b0;
      s_d = s_q;

      s_d.sync1 = {slave_addr_sel, hw_subaddr_bit2, hw_subaddr_bit1, hw_subaddr_bit0, sda_in, scl_in};
      s_d.sync2 = s_q.sync1;
      s_d.sync3 = s_q.sync2;
      for (int p = 0; p < PIN_COUNT; p++) begin
         if (s_q.sync2[p] == s_q.sync3[p]) begin
            s_d.lvl[p] = s_q.sync3[p];
         end
      end
      s_d.prev = s_q.lvl[1:0];

      if (start_c) begin
         s_d.rx = RX_ADDR;
         s_d.bitcnt = 4'h0;
         s_d.pending = 1'b0;
         s_d.ack = 1'b0;
      end else if (stop_c) begin
         s_d.rx = RX_IDLE; // R19
         s_d.bitcnt = 4'h0;
         s_d.pending = 1'b0;
         s_d.ack = 1'b0;
      end else if (s_q.rx != RX_IDLE) begin
         if (scl_rise && s_q.bitcnt < 4'h9) begin
            if (s_q.bitcnt < 4'h8) begin
               s_d.shift = {s_q.shift[6:0], sda_f};
            end
            s_d.bitcnt = s_q.bitcnt + 4'h1;
         end
         if (scl_fall && s_q.bitcnt == 4'h8) begin
            s_d.pending = 1'b1;
         end
         if (scl_fall && s_q.bitcnt == 4'h9) begin
            s_d.ack = 1'b0; // R18
            s_d.bitcnt = 4'h0;
         end
         if (take_c) begin
            s_d.pending = 1'b0;
            unique case (s_q.rx)
               RX_ADDR: begin
                  s_d.ack = addr_ok; // R22
                  s_d.rx = addr_ok ? RX_CMD : RX_IDLE;
               end
               RX_CMD: begin
                  s_d.ack = 1'b1; // R18
                  if (!s_q.shift[CMD_CONT_BIT]) begin
                     s_d.rx = RX_DATA;
                  end
                  unique case (s_q.shift[6:5])
                     OP_PTR: s_d.ptr = s_q.shift[4:0];
                     OP_MODE: begin
                        s_d.cfg.low_power = s_q.shift[4];
                        s_d.cfg.enable = s_q.shift[3]; // R16
                        s_d.cfg.bias_half = s_q.shift[2];
                        s_d.cfg.mode = drive_mode_e'(s_q.shift[1:0]);
                     end
                     OP_RSVD: begin
                     end
                     OP_EXT: begin
                        if (s_q.shift[4:3] == EXT_DEVSEL) begin
                           s_d.subaddr = s_q.shift[2:0]; // R5 R26
                        end else if (s_q.shift[4:3] == EXT_BANK && !s_q.shift[2]) begin
                           s_d.cfg.in_bank = s_q.shift[1]; // R12
                           s_d.cfg.out_bank = s_q.shift[0]; // R12
                        end else if (s_q.shift[4:3] == EXT_BLINK) begin
                           s_d.cfg.blink_alt = s_q.shift[2]; // R25
                           s_d.cfg.blink_rate = s_q.shift[1:0]; // R25
                        end
                     end
                  endcase
               end
               RX_DATA: begin
                  s_d.ack = match_cur || (match_next && ovf_c); // R18
                  s_d.ptr = next_ptr_c; // R2 R23
                  if (ovf_c) begin
                     s_d.subaddr = s_q.subaddr + 3'h1; // R3
                  end
               end
               RX_IDLE: begin
               end
            endcase
         end
      end

      if (s_q.cfg.blink_rate == 2'h0) begin
         s_d.blink_cnt = '0;
         s_d.blink_on = 1'b1;
      end else if (s_q.blink_cnt >= half_c - 19'h1) begin
         s_d.blink_cnt = '0; // R13 R14
         s_d.blink_on = !s_q.blink_on;
      end else begin
         s_d.blink_cnt = s_q.blink_cnt + 19'h1;
      end

      if (!s_q.busy) begin
         if (fifo_out_valid) begin
            s_d.busy = 1'b1;
            s_d.job = fifo_out_data;
            s_d.k = 3'h0;
            s_d.wait_cnt = 8'h00;
         end
      end else if (s_q.wait_cnt != 8'h00) begin
         s_d.wait_cnt = s_q.wait_cnt - 8'h01;
      end else begin
         a6 = {1'b0, s_q.job.ptr} + {3'b000, s_q.k};
         a = (a6 >= 6'd24) ? 5'(a6 - 6'd24) : a6[4:0];
         en = (a6 >= 6'd24) ? s_q.job.match_next : s_q.job.match_cur; // R1 R4
         base = (s_q.job.bank && (s_q.job.mode == MODE_STATIC || s_q.job.mode == MODE_1_2)) ? 2'h2 : 2'h0; // R11 R24
         b = int'(bits_of(s_q.job.mode));
         for (int j = 0; j < RAM_BITS; j++) begin
            idx = int'(s_q.k) * b + j;
            if (j < b && idx < 8 && en) begin
               s_d.ram[a][int'(base) + j] = s_q.job.data[7 - idx];
               we_c = 1'b1;
            end
         end
         if ({1'b0, s_q.k} == 4'(step_of(s_q.job.mode) - 4'h1)) begin
            s_d.busy = 1'b0;
         end else begin
            s_d.k = s_q.k + 3'h1;
         end
         s_d.wait_cnt = s_q.cfg.low_power ? LP_STEP_WAIT : 8'h00; // R21
      end

      if ({1'b0, s_q.phase} >= bits_of(s_q.cfg.mode)) begin
         s_d.phase = 2'h0;
      end else if (mux_step) begin
         s_d.phase = ({1'b0, s_q.phase} + 3'h1 >= bits_of(s_q.cfg.mode)) ? 2'h0 : s_q.phase + 2'h1; // R6 R7 R8
      end
      for (int w = 0; w < RAM_WORDS; w++) begin
         s_d.seg[w] = !blank_c && s_q.ram[w][row_c]; // R9 R10 R16
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         s_q <= '0;
         s_q.cfg <= CFG_RST;
         s_q.ptr <= PTR_RST;
         s_q.subaddr <= SUBADDR_RST;
         s_q.blink_on <= 1'b1;
      end else if (clk_en) begin
         s_q <= s_d;
      end
   end

   job_fifo #(.WIDTH(JOB_W), .DEPTH(FIFO_DEPTH)) u_job_fifo (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .clk_en(clk_en),
      .in_valid(need_push),
      .in_ready(fifo_in_ready),
      .in_data(job_c),
      .out_valid(fifo_out_valid),
      .out_ready(!s_q.busy),
      .out_data(fifo_out_data)
   );

   assign scl_out = 1'b0;
   assign scl_oe = s_q.pending; // R21
   assign sda_out = 1'b0;
   assign sda_oe = s_q.ack; // R17 R18
   assign bp_phase = s_q.phase;
   assign seg_data = s_q.seg;
   assign drive_mode_hi = s_q.cfg.mode[1];
   assign drive_mode_lo = s_q.cfg.mode[0];
   assign bias_half = s_q.cfg.bias_half;
   assign low_power_select = s_q.cfg.low_power;
   assign display_enable = s_q.cfg.enable;

   sequence s_push_blocked;
      s_q.pending && need_push && !fifo_in_ready;
   endsequence

   sequence s_data_taken;
      take_c && (s_q.rx == RX_DATA);
   endsequence

   property p_ack_window;
      @(posedge ref_clk) disable iff (!rst_n || !clk_en) sda_oe |-> (s_q.bitcnt >= 4'h8);
   endproperty
   a_ack_window: assert property (p_ack_window) else $error("sda driven outside acknowledge slot"); // R17

   property p_stop_idle;
      @(posedge ref_clk) disable iff (!rst_n || !clk_en) stop_c |=> (s_q.rx == RX_IDLE) && !sda_oe;
   endproperty
   a_stop_idle: assert property (p_stop_idle) else $error("stop did not return to idle"); // R19

   property p_stretch_hold;
      @(posedge ref_clk) disable iff (!rst_n || !clk_en) s_push_blocked and (!start_c && !stop_c) |=> scl_oe;
   endproperty
   a_stretch_hold: assert property (p_stretch_hold) else $error("scl released while buffer full"); // R21

   property p_no_store_mismatch;
      @(posedge ref_clk) disable iff (!rst_n || !clk_en)
         s_q.busy && (s_q.wait_cnt == '0) && !s_q.job.match_cur && (s_q.job.ptr + 6'(s_q.k) < 6'd24) |-> !we_c;
   endproperty
   a_no_store_mismatch: assert property (p_no_store_mismatch) else $error("store with foreign subaddress"); // R1

   property p_static_step;
      @(posedge ref_clk) disable iff (!rst_n || !clk_en)
         s_data_taken and (s_q.cfg.mode == MODE_STATIC) && (s_q.ptr < 5'd16) |=> s_q.ptr == $past(s_q.ptr) + 5'd8;
   endproperty
   a_static_step: assert property (p_static_step) else $error("static pointer step is not eight"); // R2

   property p_sub_inc;
      @(posedge ref_clk) disable iff (!rst_n || !clk_en)
         s_data_taken and ovf_c |=> s_q.subaddr == $past(s_q.subaddr) + 3'h1;
   endproperty
   a_sub_inc: assert property (p_sub_inc) else $error("subaddress not advanced on overflow"); // R3

   property p_blank;
      @(posedge ref_clk) disable iff (!rst_n || !clk_en) !s_q.cfg.enable [*2] |-> (seg_data == '0);
   endproperty
   a_blank: assert property (p_blank) else $error("segments active while disabled"); // R16

   property p_blink_bound;
      @(posedge ref_clk) disable iff (!rst_n || !clk_en)
         (s_q.cfg.blink_rate == 2'h0) |=> (s_q.blink_cnt == '0) && s_q.blink_on;
   endproperty
   a_blink_bound: assert property (p_blink_bound) else $error("blinker running while off"); // R13

   property p_bank_ignored;
      @(posedge ref_clk) disable iff (!rst_n || !clk_en) !bankable |-> (row_c == s_q.phase);
   endproperty
   a_bank_ignored: assert property (p_bank_ignored) else $error("bank used in three or four plane mode"); // R24

endmodule : lcd_ram_bank_blink_control

//--- pkg/lcd_ctl_pkg.sv
// Shared constants, types and helpers of the display RAM, bank and blink control.
package lcd_ctl_pkg;

   localparam int RAM_WORDS = 24;
   localparam int RAM_BITS = 4;
   localparam int FIFO_DEPTH_DEF = 8;

   // Pin slots of the input synchroniser.
   localparam int PIN_SCL = 0;
   localparam int PIN_SDA = 1;
   localparam int PIN_SUB0 = 2;
   localparam int PIN_SA = 5;
   localparam int PIN_COUNT = 6;

   // Upper six bits of the slave address byte; bit 1 is the strap, bit 0 the write flag.
   localparam logic [5:0] SLAVE_ADDR_HI = 6'h1f;

   // Command byte fields.
   localparam int CMD_CONT_BIT = 7;
   localparam logic [1:0] OP_PTR = 2'h0;
   localparam logic [1:0] OP_RSVD = 2'h1;
   localparam logic [1:0] OP_MODE = 2'h2;
   localparam logic [1:0] OP_EXT = 2'h3;
   localparam logic [1:0] EXT_DEVSEL = 2'h0;
   localparam logic [1:0] EXT_BLINK = 2'h2;
   localparam logic [1:0] EXT_BANK = 2'h3;

   // Pause between RAM word writes in power-saving mode, in clock cycles.
   localparam logic [7:0] LP_STEP_WAIT = 8'h04;

   typedef enum logic [1:0] {
      MODE_1_4 = 2'b00,
      MODE_STATIC = 2'b01,
      MODE_1_2 = 2'b10,
      MODE_1_3 = 2'b11
   } drive_mode_e;

   typedef enum logic [1:0] {
      RX_IDLE = 2'b00,
      RX_ADDR = 2'b01,
      RX_CMD = 2'b10,
      RX_DATA = 2'b11
   } rx_state_e;

   typedef struct packed {
      drive_mode_e mode;
      logic enable;
      logic bias_half;
      logic low_power;
      logic in_bank;
      logic out_bank;
      logic [1:0] blink_rate;
      logic blink_alt;
   } cfg_s;

   localparam cfg_s CFG_RST = '{mode: MODE_1_4, enable: 1'b0, bias_half: 1'b0, low_power: 1'b0,
                                in_bank: 1'b0, out_bank: 1'b0, blink_rate: 2'h0, blink_alt: 1'b0};
   localparam logic [4:0] PTR_RST = 5'h00;
   localparam logic [2:0] SUBADDR_RST = 3'h0;

   typedef struct packed {
      logic [4:0] ptr;
      logic match_cur;
      logic match_next;
      drive_mode_e mode;
      logic bank;
      logic [7:0] data;
   } write_job_s;

   localparam int JOB_W = $bits(write_job_s);

   function automatic logic [3:0] step_of(input drive_mode_e m);
      unique case (m)
         MODE_STATIC: step_of = 4'h8;
         MODE_1_2: step_of = 4'h4;
         MODE_1_3: step_of = 4'h3;
         MODE_1_4: step_of = 4'h2;
      endcase
   endfunction : step_of

   function automatic logic [2:0] bits_of(input drive_mode_e m);
      unique case (m)
         MODE_STATIC: bits_of = 3'h1;
         MODE_1_2: bits_of = 3'h2;
         MODE_1_3: bits_of = 3'h3;
         MODE_1_4: bits_of = 3'h4;
      endcase
   endfunction : bits_of

endpackage : lcd_ctl_pkg

//--- tb/i2c_host_model.sv
// Bus master model that sends write transfers and samples acknowledges.
module i2c_host_model (
   // Clock and wire levels.
   input wire logic ref_clk,
   input wire logic scl_wire,
   input wire logic sda_wire,
   // Pull-downs of the master.
   output logic scl_low,
   output logic sda_low
);
   timeunit 1ns;
   timeprecision 1ns;
   localparam int HALF = 12;
   initial begin
      scl_low = 1'b0;
      sda_low = 1'b0;
   end
   task automatic tick(input int n);
      repeat (n) @(negedge ref_clk);
   endtask : tick
   // Releases SCL, waits out any stretch, and reports SDA over the high phase.
   task automatic clk_high(output logic lvl);
      int w;
      w = 0;
      scl_low = 1'b0;
      do begin
         tick(1);
         w++;
      end while (scl_wire !== 1'b1 && w < 4000);
      lvl = sda_wire;
      tick(HALF);
      lvl = lvl | sda_wire;
   endtask : clk_high
   task automatic start_cond();
      sda_low = 1'b1;
      tick(HALF);
      scl_low = 1'b1;
   endtask : start_cond
   task automatic stop_cond();
      logic s;
      sda_low = 1'b1;
      tick(HALF);
      clk_high(s);
      sda_low = 1'b0;
      tick(HALF);
   endtask : stop_cond
   task automatic send_byte(input logic [7:0] d, output logic nack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         sda_low = ~d[i];
         tick(HALF);
         clk_high(s);
         scl_low = 1'b1;
      end
      sda_low = 1'b0;
      tick(HALF);
      clk_high(nack);
      scl_low = 1'b1;
   endtask : send_byte
endmodule : i2c_host_model

//--- tb/lcd_ram_bank_blink_control_bench.sv
// Self-checking bench of the display RAM, bank and blink control.
module lcd_ram_bank_blink_control_bench;
   timeunit 1ns;
   timeprecision 1ns;
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic mux_step = 1'b0;
   logic scl_low, sda_low, scl_oe, sda_oe, scl_out, sda_out, mhi, mlo;
   logic [1:0] bp_phase;
   logic [23:0] seg_data;
   localparam int DIV_N1 = 40;
   localparam int DIV_N2 = 80;
   localparam int DIV_N3 = 160;
   localparam int DIV_P1 = 20;
   localparam int DIV_P2 = 40;
   localparam int DIV_P3 = 80;
   logic clk_en = 1'b1;
   logic sa_sel = 1'b0;
   logic [2:0] strap = 3'h1;
   logic bias_o, lp_o, en_o;
   int failures = 0;
   int checks_done = 0;
   wire logic scl_wire = ~(scl_low | (scl_oe & ~scl_out));
   wire logic sda_wire = ~(sda_low | (sda_oe & ~sda_out));
   always #25 ref_clk = ~ref_clk;
   lcd_ram_bank_blink_control #(.BLINK_DIV_N1(DIV_N1), .BLINK_DIV_N2(DIV_N2), .BLINK_DIV_N3(DIV_N3),
      .BLINK_DIV_P1(DIV_P1), .BLINK_DIV_P2(DIV_P2), .BLINK_DIV_P3(DIV_P3)) u_dut (
      .ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en),
      .scl_in(scl_wire), .scl_out(scl_out), .scl_oe(scl_oe),
      .sda_in(sda_wire), .sda_out(sda_out), .sda_oe(sda_oe),
      .hw_subaddr_bit0(strap[0]), .hw_subaddr_bit1(strap[1]), .hw_subaddr_bit2(strap[2]), .slave_addr_sel(sa_sel),
      .mux_step(mux_step), .bp_phase(bp_phase), .seg_data(seg_data),
      .drive_mode_hi(mhi), .drive_mode_lo(mlo), .bias_half(bias_o), .low_power_select(lp_o), .display_enable(en_o));
   i2c_host_model u_host (.ref_clk(ref_clk), .scl_wire(scl_wire), .sda_wire(sda_wire),
      .scl_low(scl_low), .sda_low(sda_low));
   task automatic finish_test();
      if (failures == 0 && checks_done > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : finish_test
   task automatic cmp_v(input logic [23:0] got, input logic [23:0] exp);
      checks_done++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : cmp_v
   task automatic do_reset();
      rst_n = 1'b0;
      repeat (8) @(negedge ref_clk);
      rst_n = 1'b1;
      repeat (8) @(negedge ref_clk);
   endtask : do_reset
   // One write transfer to the device; bit i of nk is the answer to byte i, address first.
   task automatic xfer(input logic [7:0] q[$], output logic [15:0] nk);
      logic n;
      nk = '0;
      u_host.start_cond();
      u_host.send_byte(8'h7c, n);
      nk[0] = n;
      foreach (q[i]) begin
         u_host.send_byte(q[i], n);
         nk[i+1] = n;
      end
      u_host.stop_cond();
      repeat (60) @(negedge ref_clk);
   endtask : xfer
   task automatic t_mux(input logic [7:0] mc, input int b);
      logic [15:0] nk;
      logic [7:0] d[2];
      logic [23:0] e;
      int st, i;
      d[0] = 8'h1b;
      d[1] = 8'hc6;
      st = (8 + b - 1) / b;
      do_reset();
      xfer('{mc, 8'he1, 8'h00, d[0], d[1]}, nk);
      cmp_v(24'(nk), 24'h0);
      cmp_v(24'({mhi, mlo}), 24'(mc[1:0]));
      for (int p = 0; p <= b; p++) begin
         e = '0;
         for (int w = 0; w < 2 * st; w++) begin
            i = (w % st) * b + (p % b);
            if (i < 8) e[w] = d[w / st][7 - i];
         end
         cmp_v(seg_data, e);
         cmp_v(24'(bp_phase), 24'(p % b));
         mux_step = 1'b1;
         @(negedge ref_clk);
         mux_step = 1'b0;
         repeat (3) @(negedge ref_clk);
      end
      // A step offered while the clock enable is low must not move the phase.
      clk_en = 1'b0;
      mux_step = 1'b1;
      @(negedge ref_clk);
      mux_step = 1'b0;
      repeat (2) @(negedge ref_clk);
      cmp_v(24'(bp_phase), 24'((b + 1) % b));
      clk_en = 1'b1;
   endtask : t_mux
   task automatic t_bank();
      logic [15:0] nk;
      do_reset();
      xfer('{8'hc9, 8'hfa, 8'he1, 8'h00, 8'h81}, nk);
      cmp_v(seg_data, 24'h0);
      xfer('{8'h7b}, nk);
      cmp_v(seg_data, 24'h000081);
      xfer('{8'h48}, nk);
      cmp_v(seg_data, 24'h0);
   endtask : t_bank
   task automatic t_cascade();
      logic [15:0] nk;
      logic n;
      do_reset();
      xfer('{8'hc9, 8'he0, 8'h0c, 8'hff, 8'hff, 8'hff}, nk);
      cmp_v(24'(nk), 24'h10);
      cmp_v(seg_data, 24'h000fff);
      for (int a = 0; a < 2; a++) begin
         u_host.start_cond();
         u_host.send_byte(8'(8'h7d + a), n);
         u_host.stop_cond();
         cmp_v(24'(n), 24'h1);
      end
      sa_sel = 1'b1;
      u_host.start_cond();
      u_host.send_byte(8'h7e, n);
      u_host.stop_cond();
      sa_sel = 1'b0;
      cmp_v(24'(n), 24'h0);
      xfer('{8'h41}, nk);
      cmp_v(seg_data, 24'h0);
      cmp_v(24'({en_o, bias_o}), 24'h0);
      xfer('{8'h4d}, nk);
      cmp_v(seg_data, 24'h000fff);
      cmp_v(24'({en_o, bias_o}), 24'h3);
      strap = 3'h6;
      xfer('{8'he6, 8'h00, 8'h00}, nk);
      strap = 3'h1;
      cmp_v(24'(nk), 24'h0);
      cmp_v(seg_data, 24'h000f00);
   endtask : t_cascade
   // Measures one on-plus-off span of the blinking display.
   task automatic t_blink(input logic [7:0] mc, input logic [7:0] bc, input int div);
      logic [15:0] nk;
      int n, c;
      n = 0;
      do_reset();
      xfer('{mc, 8'he1, bc, 8'h00, 8'hff}, nk);
      cmp_v(24'(lp_o), 24'(mc[4]));
      for (int k = 0; k < 4; k++) begin
         c = 0;
         while ((seg_data === 24'h0) == k[0] && c < 4000) begin
            @(negedge ref_clk);
            c++;
         end
         if (k > 1) n += c;
      end
      cmp_v(24'(n), 24'(div));
   endtask : t_blink
   initial begin
      do_reset();
      t_mux(8'hc8, 4);
      t_mux(8'hcb, 3);
      t_mux(8'hca, 2);
      t_mux(8'hc9, 1);
      t_bank();
      t_cascade();
      for (int r = 1; r < 4; r++) begin
         t_blink(8'hc9, 8'(8'hf0 | r), DIV_N1 << (r - 1));
         t_blink(8'hd9, 8'(8'hf0 | r), DIV_P1 << (r - 1));
      end
      t_blink(8'hc9, 8'hf5, DIV_N1);
      finish_test();
   end
   initial begin
      repeat (80000) @(negedge ref_clk);
      failures++;
      finish_test();
   end
endmodule : lcd_ram_bank_blink_control_bench
